// ---- rtl/tmr8s_top.sv ----
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tmr8s_params.svh"
// one 8-bit timer channel: counter, compares, status flags, output pin
module tmr8s_top
   import tmr8s_pkg::*;
#(
   parameter int CHANNEL = 0 // channel number 0..3, shapes bit four
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [`TMR8S_ADDR_W-1:0] addr_i,
   input wire logic [`TMR8S_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`TMR8S_DATA_W-1:0] rdata_o,
   input wire logic count_tick_i,
   input wire logic ext_reset_i,
   input wire logic dtc_act_first_i,
   input wire logic dtc_act_second_i,
   input wire logic transfer_disable_select_i,
   output logic timer_out_o,
   output logic adc_start_o,
   output logic match_irq_first_o,
   output logic match_irq_second_o,
   output logic wrap_irq_o,
   output logic irq_o
);
   // channel shape, fixed at elaboration
   localparam logic IS_CH0 = (CHANNEL == 0);
   localparam logic BIT4_FIXED = (CHANNEL == 1) || (CHANNEL == 3);

   // counter and compare registers
   logic [7:0] timer_count_value_q;  // running count
   logic [7:0] timer_count_value_d;  // next count
   logic [7:0] compare_const_first_q;  // compare constant first
   logic [7:0] compare_const_second_q; // compare constant second

   // control register fields
   logic wrap_irq_enable_q;   // overflow interrupt enable
   tmr8s_clr_t clear_sel_q;   // counter clearing source

   // status/control writable fields
   logic bit4_q;              // trigger enable on ch0, plain bit on ch2
   tmr8s_os_t os_first_q;
   tmr8s_os_t os_second_q;

   // flags from the flag helper
   logic [`TMR8S_EV_N-1:0] flags_w;

   // sticky interrupt status and mask
   logic [`TMR8S_EV_N-1:0] irq_stat_q;
   logic [`TMR8S_EV_N-1:0] irq_mask_q;

   // events of this cycle
   logic match_first_w;
   logic match_second_w;
   logic wrap_w;
   logic ext_prev_q;     // last sampled external reset level
   logic ext_rise_w;     // rising edge on external reset
   logic clear_w;        // counter clear this cycle

   // decoded bus strobes
   logic wr_count_w;
   logic wr_cmp_first_w;
   logic wr_cmp_second_w;
   logic wr_ctrl_w;
   logic wr_sc_w;
   logic wr_istat_w;
   logic wr_imask_w;
   logic rd_sc_w;
   logic [`TMR8S_DATA_W-1:0] rd_mux_w;
   logic [`TMR8S_DATA_W-1:0] sc_view_w;

   tmr8s_if ev_bus ();

   // decode a read or write strobe for one offset
   function automatic logic hit(input logic [`TMR8S_ADDR_W-1:0] a, input logic [`TMR8S_ADDR_W-1:0] off,
                                input logic stb);
      hit = stb && (a == off);
   endfunction : hit

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------

   // write strobes, one per register
   assign wr_count_w = hit(addr_i, `TMR8S_OFF_COUNT, wr_i);
   assign wr_cmp_first_w = hit(addr_i, `TMR8S_OFF_CMP_FIRST, wr_i);
   assign wr_cmp_second_w = hit(addr_i, `TMR8S_OFF_CMP_SECOND, wr_i);
   assign wr_ctrl_w = hit(addr_i, `TMR8S_OFF_CTRL, wr_i);
   assign wr_sc_w = hit(addr_i, `TMR8S_OFF_STATUS_CTRL, wr_i);
   assign wr_istat_w = hit(addr_i, `TMR8S_OFF_IRQ_STAT, wr_i);
   assign wr_imask_w = hit(addr_i, `TMR8S_OFF_IRQ_MASK, wr_i);
   // a status read arms the flag clear sequence
   assign rd_sc_w = hit(addr_i, `TMR8S_OFF_STATUS_CTRL, rd_i);

   // ---------------------------------------------------------------
   // compare and wrap events
   // ---------------------------------------------------------------

   // a match fires in the last state of equality, on the tick that
   // would move the counter on, so one equal value yields one event
   assign match_first_w = count_tick_i && (timer_count_value_q == compare_const_first_q);
   assign match_second_w = count_tick_i && (timer_count_value_q == compare_const_second_q);

   // external reset edge; inputs are synchronous so one stage suffices
   assign ext_rise_w = ext_reset_i && !ext_prev_q;

   // clearing source picked by the control register
   always_comb begin
      unique case (clear_sel_q)
         TMR8S_CLR_NONE: clear_w = 1'b0;
         TMR8S_CLR_FIRST: clear_w = match_first_w;
         TMR8S_CLR_SECOND: clear_w = match_second_w;
         TMR8S_CLR_EXT: clear_w = ext_rise_w;
      endcase
   end

   // wrap only when the counter really passes FF to 00 on a tick;
   // a match clear at FF also lands on zero, and still counts as wrap
   assign wrap_w = count_tick_i && (timer_count_value_q == `TMR8S_COUNT_MAX);

   // next count: software write first, then clear, then increment
   always_comb begin
      timer_count_value_d = timer_count_value_q;
      if (wr_count_w) begin
         timer_count_value_d = wdata_i;
      end else if (clear_w) begin
         timer_count_value_d = `TMR8S_ZERO8;
      end else if (count_tick_i) begin
         timer_count_value_d = timer_count_value_q + 8'h01;
      end
   end

   // counter register
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         timer_count_value_q <= `TMR8S_ZERO8;
      end else if (ce_i) begin
         timer_count_value_q <= timer_count_value_d;
      end
   end

   // external reset sampler, for edge detection only
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ext_prev_q <= 1'b0;
      end else if (ce_i) begin
         ext_prev_q <= ext_reset_i;
      end
   end

   // ---------------------------------------------------------------
   // compare constants
   // ---------------------------------------------------------------

   // both constants reset to the top value, so a tick at count FF matches before setup
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         compare_const_first_q <= `TMR8S_CMP_RST;
         compare_const_second_q <= `TMR8S_CMP_RST;
      end else if (ce_i) begin
         if (wr_cmp_first_w) begin
            compare_const_first_q <= wdata_i;
         end
         if (wr_cmp_second_w) begin
            compare_const_second_q <= wdata_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------

   // overflow enable and clear select
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wrap_irq_enable_q <= 1'b0;
         clear_sel_q <= TMR8S_CLR_NONE;
      end else if (ce_i && wr_ctrl_w) begin
         wrap_irq_enable_q <= wdata_i[`TMR8S_BIT_WRAP_IE];
         clear_sel_q <= tmr8s_clr_t'(wdata_i[`TMR8S_CCL_HI:`TMR8S_CCL_LO]);
      end
   end

   // ---------------------------------------------------------------
   // status/control register, writable low five bits (low four on channels one and three)
   // ---------------------------------------------------------------

   // select fields and bit four; flags go to the helper
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         bit4_q <= 1'b0;
         os_first_q <= TMR8S_OS_KEEP;
         os_second_q <= TMR8S_OS_KEEP;
      end else if (ce_i && wr_sc_w) begin
         // fixed channels keep bit four out of reach of writes
         if (!BIT4_FIXED) begin
            bit4_q <= wdata_i[`TMR8S_BIT_TRIG];
         end
         os_first_q <= tmr8s_os_t'(wdata_i[`TMR8S_OSA_HI:`TMR8S_OSA_LO]);
         os_second_q <= tmr8s_os_t'(wdata_i[`TMR8S_OSB_HI:`TMR8S_OSB_LO]);
      end
   end

   // ---------------------------------------------------------------
   // events to the helpers
   // ---------------------------------------------------------------
   assign ev_bus.ev_first = match_first_w;
   assign ev_bus.ev_second = match_second_w;
   assign ev_bus.ev_wrap = wrap_w;
   assign ev_bus.os_first = os_first_q;
   assign ev_bus.os_second = os_second_q;

   // status flags with their clearing sequences
   tmr8s_flags u_flags (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .ev(ev_bus.snk),
      .status_rd_i(rd_sc_w),
      .status_wr_i(wr_sc_w),
      .wr_bits_i({wdata_i[`TMR8S_BIT_FLAG_SECOND], wdata_i[`TMR8S_BIT_FLAG_FIRST], wdata_i[`TMR8S_BIT_WRAP]}),
      .dtc_clr_first_i(dtc_act_first_i && !transfer_disable_select_i),
      .dtc_clr_second_i(dtc_act_second_i && !transfer_disable_select_i),
      .flags_o(flags_w)
   );

   // output pin and converter trigger; trigger exists on ch0 only
   tmr8s_outctl u_outctl (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .ev(ev_bus.snk),
      .trig_en_i(IS_CH0 && bit4_q),
      .timer_out_o(timer_out_o),
      .adc_start_o(adc_start_o)
   );

   // ---------------------------------------------------------------
   // interrupt requests
   // ---------------------------------------------------------------

   // per-source requests follow the flags; overflow needs its enable
   assign match_irq_first_o = flags_w[`TMR8S_EV_FIRST];
   assign match_irq_second_o = flags_w[`TMR8S_EV_SECOND];
   assign wrap_irq_o = flags_w[`TMR8S_EV_WRAP] && wrap_irq_enable_q;

   // sticky summary status, write one to clear, set wins the tie
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_stat_q <= `TMR8S_ZERO3;
      end else if (ce_i) begin
         irq_stat_q <= {match_second_w, match_first_w, wrap_w} |
                       (irq_stat_q & ~({`TMR8S_EV_N{wr_istat_w}} & wdata_i[`TMR8S_EV_N-1:0]));
      end
   end

   // summary mask, same layout
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_mask_q <= `TMR8S_ZERO3;
      end else if (ce_i && wr_imask_w) begin
         irq_mask_q <= wdata_i[`TMR8S_EV_N-1:0];
      end
   end

   // level output, straight from registers, no glitch path
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------

   // status/control as software sees it
   always_comb begin
      sc_view_w = `TMR8S_ZERO8;
      sc_view_w[`TMR8S_BIT_FLAG_SECOND] = flags_w[`TMR8S_EV_SECOND];
      sc_view_w[`TMR8S_BIT_FLAG_FIRST] = flags_w[`TMR8S_EV_FIRST];
      sc_view_w[`TMR8S_BIT_WRAP] = flags_w[`TMR8S_EV_WRAP];
      sc_view_w[`TMR8S_BIT_TRIG] = BIT4_FIXED ? `TMR8S_BIT_RO_ONE : bit4_q;
      sc_view_w[`TMR8S_OSB_HI:`TMR8S_OSB_LO] = os_second_q;
      sc_view_w[`TMR8S_OSA_HI:`TMR8S_OSA_LO] = os_first_q;
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_mux_w = `TMR8S_ZERO8;
      unique case (addr_i)
         `TMR8S_OFF_COUNT: rd_mux_w = timer_count_value_q;
         `TMR8S_OFF_CMP_FIRST: rd_mux_w = compare_const_first_q;
         `TMR8S_OFF_CMP_SECOND: rd_mux_w = compare_const_second_q;
         `TMR8S_OFF_CTRL: begin
            rd_mux_w[`TMR8S_BIT_WRAP_IE] = wrap_irq_enable_q;
            rd_mux_w[`TMR8S_CCL_HI:`TMR8S_CCL_LO] = clear_sel_q;
         end
         `TMR8S_OFF_STATUS_CTRL: rd_mux_w = sc_view_w;
         `TMR8S_OFF_IRQ_STAT: rd_mux_w[`TMR8S_EV_N-1:0] = irq_stat_q;
         `TMR8S_OFF_IRQ_MASK: rd_mux_w[`TMR8S_EV_N-1:0] = irq_mask_q;
         default: rd_mux_w = `TMR8S_ZERO8;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         rdata_o <= `TMR8S_ZERO8;
      end else if (ce_i) begin
         rdata_o <= rd_i ? rd_mux_w : `TMR8S_ZERO8;
      end
   end
endmodule : tmr8s_top
`default_nettype wire

// ---- shared/tmr8s_params.svh ----
// Overview of operation
// - match flag second set on counter equal compare
// - controller activation clears match flag second
// - match flag first set on counter equal compare
// - controller activation clears match flag first
// - wrap flag set when counter passes FF
// - wrap flag cleared by read-one-then-write-zero
// - written one leaves status flags unchanged
// - channel zero trigger enable issues converter start
// - second select: keep, low, high, toggle
// - first select: keep, low, high, toggle
// - channels one, three: bit four reads one
// - wrap request only when wrap enable set
// - clear select: none, first, second, external edge
`ifndef TMR8S_PARAMS_SVH
`define TMR8S_PARAMS_SVH

// register bus geometry
`define TMR8S_ADDR_W 4
`define TMR8S_DATA_W 8

// register offsets
`define TMR8S_OFF_COUNT 4'h0
`define TMR8S_OFF_CMP_FIRST 4'h1
`define TMR8S_OFF_CMP_SECOND 4'h2
`define TMR8S_OFF_CTRL 4'h3
`define TMR8S_OFF_STATUS_CTRL 4'h4
`define TMR8S_OFF_IRQ_STAT 4'h5
`define TMR8S_OFF_IRQ_MASK 4'h6

// status/control register fields
`define TMR8S_BIT_FLAG_SECOND 7
`define TMR8S_BIT_FLAG_FIRST 6
`define TMR8S_BIT_WRAP 5
`define TMR8S_BIT_TRIG 4
`define TMR8S_OSB_HI 3
`define TMR8S_OSB_LO 2
`define TMR8S_OSA_HI 1
`define TMR8S_OSA_LO 0

// control register fields
`define TMR8S_BIT_WRAP_IE 5
`define TMR8S_CCL_HI 4
`define TMR8S_CCL_LO 3

// event bit positions, shared by flags and interrupt registers
`define TMR8S_EV_WRAP 0
`define TMR8S_EV_FIRST 1
`define TMR8S_EV_SECOND 2
`define TMR8S_EV_N 3

// counter limits and reset values
`define TMR8S_COUNT_MAX 8'hFF
`define TMR8S_CMP_RST 8'hFF
`define TMR8S_ZERO8 8'h00
`define TMR8S_ZERO3 3'h0
`define TMR8S_BIT_RO_ONE 1'h1

`endif

// ---- shared/tmr8s_pkg.sv ----
package tmr8s_pkg;
   // output action selected by a two-bit select field
   typedef enum logic [1:0] {
      TMR8S_OS_KEEP = 2'b00,
      TMR8S_OS_LOW = 2'b01,
      TMR8S_OS_HIGH = 2'b10,
      TMR8S_OS_TOGGLE = 2'b11
   } tmr8s_os_t;
   // counter clearing source
   typedef enum logic [1:0] {
      TMR8S_CLR_NONE = 2'b00,
      TMR8S_CLR_FIRST = 2'b01,
      TMR8S_CLR_SECOND = 2'b10,
      TMR8S_CLR_EXT = 2'b11
   } tmr8s_clr_t;
endpackage : tmr8s_pkg

// ---- shared/tmr8s_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// compare events and output selects shared by the top and its helpers
interface tmr8s_if;
   import tmr8s_pkg::*;
   logic ev_first;      // compare-match first, one cycle
   logic ev_second;     // compare-match second, one cycle
   logic ev_wrap;       // counter wrap, one cycle
   tmr8s_os_t os_first;  // first output select
   tmr8s_os_t os_second; // second output select
   modport src (output ev_first, output ev_second, output ev_wrap, output os_first, output os_second);
   modport snk (input ev_first, input ev_second, input ev_wrap, input os_first, input os_second);
endinterface : tmr8s_if
`default_nettype wire

// ---- rtl/tmr8s_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr8s_params.svh"
// three status flags with read-then-write-zero and controller clears
module tmr8s_flags
   import tmr8s_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   tmr8s_if.snk ev,
   input wire logic status_rd_i,               // status register read
   input wire logic status_wr_i,               // status register write
   input wire logic [`TMR8S_EV_N-1:0] wr_bits_i, // written flag values
   input wire logic dtc_clr_first_i,           // controller clear, first
   input wire logic dtc_clr_second_i,          // controller clear, second
   output logic [`TMR8S_EV_N-1:0] flags_o
);
   logic [`TMR8S_EV_N-1:0] set_w;   // hardware set events
   logic [`TMR8S_EV_N-1:0] armed_q; // flag seen as one by a read
   logic [`TMR8S_EV_N-1:0] sw_clr_w;
   logic [`TMR8S_EV_N-1:0] dtc_clr_w;

   always_comb begin
      set_w = `TMR8S_ZERO3;
      set_w[`TMR8S_EV_WRAP] = ev.ev_wrap;
      set_w[`TMR8S_EV_FIRST] = ev.ev_first;
      set_w[`TMR8S_EV_SECOND] = ev.ev_second;
      dtc_clr_w = `TMR8S_ZERO3;
      dtc_clr_w[`TMR8S_EV_FIRST] = dtc_clr_first_i;
      dtc_clr_w[`TMR8S_EV_SECOND] = dtc_clr_second_i;
   end

   // only a written zero to an armed flag clears; a written one does nothing
   assign sw_clr_w = {`TMR8S_EV_N{status_wr_i}} & ~wr_bits_i & armed_q;

   // arming remembers that software saw the flag set before its write
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         armed_q <= `TMR8S_ZERO3;
      end else if (ce_i) begin
         if (status_wr_i) begin
            armed_q <= `TMR8S_ZERO3; // any write ends the sequence
         end else if (status_rd_i) begin
            armed_q <= flags_o;
         end
      end
   end

   // set wins over every clear, so an event in the clear cycle survives
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         flags_o <= `TMR8S_ZERO3;
      end else if (ce_i) begin
         flags_o <= set_w | (flags_o & ~(sw_clr_w | dtc_clr_w));
      end
   end
endmodule : tmr8s_flags
`default_nettype wire

// ---- rtl/tmr8s_outctl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr8s_params.svh"
// timer output pin and converter start request
module tmr8s_outctl
   import tmr8s_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   tmr8s_if.snk ev,
   input wire logic trig_en_i, // converter trigger enable, already gated by channel
   output logic timer_out_o,
   output logic adc_start_o
);
   logic after_first_w;

   // level after one compare event under a select field
   function automatic logic apply_os(input tmr8s_os_t os, input logic lvl);
      unique case (os)
         TMR8S_OS_KEEP: apply_os = lvl;
         TMR8S_OS_LOW: apply_os = 1'b0;
         TMR8S_OS_HIGH: apply_os = 1'b1;
         TMR8S_OS_TOGGLE: apply_os = ~lvl;
      endcase
   endfunction : apply_os

   // both matches in one cycle: second is applied after first
   assign after_first_w = ev.ev_first ? apply_os(ev.os_first, timer_out_o) : timer_out_o;

   // level holds between events since only events load it
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         timer_out_o <= 1'b0;
      end else if (ce_i) begin
         timer_out_o <= ev.ev_second ? apply_os(ev.os_second, after_first_w) : after_first_w;
      end
   end

   // one-cycle start request per compare-match first
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         adc_start_o <= 1'b0;
      end else if (ce_i) begin
         adc_start_o <= ev.ev_first & trig_en_i;
      end
   end
endmodule : tmr8s_outctl
`default_nettype wire

// ---- tb/tmr8s_dtc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// transfer controller stand-in: serves a standing match request
module tmr8s_dtc_model (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic irq_first_i,
   input wire logic irq_second_i,
   output logic act_first_o,
   output logic act_second_o
);
   // a pending request is served again every other cycle while it stands,
   // so a flag left set while transfers were barred still gets cleared later
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         act_first_o <= 1'h0;
         act_second_o <= 1'h0;
      end else begin
         act_first_o <= irq_first_i & ~act_first_o;
         act_second_o <= irq_second_i & ~act_second_o;
      end
   end
endmodule : tmr8s_dtc_model
`default_nettype wire

// ---- tb/tmr8s_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr8s_params.svh"
// port-level checks for one timer channel
module tmr8s_props #(
   parameter int CHANNEL = 0
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [`TMR8S_ADDR_W-1:0] addr_i,
   input wire logic [`TMR8S_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [`TMR8S_DATA_W-1:0] rdata_o,
   input wire logic count_tick_i,
   input wire logic dtc_act_first_i,
   input wire logic dtc_act_second_i,
   input wire logic transfer_disable_select_i,
   input wire logic timer_out_o,
   input wire logic adc_start_o,
   input wire logic match_irq_first_o,
   input wire logic match_irq_second_o,
   input wire logic wrap_irq_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic sw_clr_first; // status write with the first flag bit at zero
   assign sw_clr_first = wr_i && addr_i == `TMR8S_OFF_STATUS_CTRL && !wdata_i[`TMR8S_BIT_FLAG_FIRST];
   a_rdata_idle_zero: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside read answer");
   a_adc_after_tick: assert property (adc_start_o && $past(ce_i) |-> $past(count_tick_i))
      else $error("converter start without a counter tick");
   a_out_holds_level: assert property ($changed(timer_out_o) |-> $past(count_tick_i) || $past(srst_i))
      else $error("timer output moved without a compare event");
   a_first_set_tick: assert property ($rose(match_irq_first_o) |-> $past(count_tick_i))
      else $error("first flag rose without a tick");
   a_second_set_tick: assert property ($rose(match_irq_second_o) |-> $past(count_tick_i))
      else $error("second flag rose without a tick");
   a_first_flag_sticky: assert property (match_irq_first_o && ce_i && !sw_clr_first &&
      !(dtc_act_first_i && !transfer_disable_select_i) |=> match_irq_first_o)
      else $error("first flag dropped without a clear");
   a_dtc_clr_first: assert property (dtc_act_first_i && !transfer_disable_select_i && ce_i && !count_tick_i
      |=> !match_irq_first_o)
      else $error("controller activation left first flag set");
   a_dtc_clr_second: assert property (dtc_act_second_i && !transfer_disable_select_i && ce_i && !count_tick_i
      |=> !match_irq_second_o)
      else $error("controller activation left second flag set");
   a_wrap_irq_cause: assert property ($rose(wrap_irq_o) |-> $past(count_tick_i) || $past(wr_i))
      else $error("wrap request rose without tick or write");
   a_irq_rise_cause: assert property ($rose(irq_o) |-> $past(count_tick_i || wr_i))
      else $error("interrupt rose without tick or write");
   c_adc_start: cover property (adc_start_o);
   c_irq_on_match: cover property (match_irq_first_o && irq_o);
   c_dtc_clear: cover property (dtc_act_second_i ##1 !match_irq_second_o);
endmodule : tmr8s_props
bind tmr8s_top tmr8s_props #(.CHANNEL(CHANNEL)) i_tmr8s_props (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tmr8s_params.svh"
// register-level test of timer channel 0, channel 1 beside it for bit four
module testbench;
   localparam logic [3:0] A_CNT = `TMR8S_OFF_COUNT;
   localparam logic [3:0] A_CA = `TMR8S_OFF_CMP_FIRST;
   localparam logic [3:0] A_CB = `TMR8S_OFF_CMP_SECOND;
   localparam logic [3:0] A_CTL = `TMR8S_OFF_CTRL;
   localparam logic [3:0] A_ST = `TMR8S_OFF_STATUS_CTRL;
   localparam logic [7:0] ORD = 8'hD2; // select order: high, keep, low, toggle
   logic clk_sys_i, srst_i, ce_i, wr_i, rd_i, count_tick_i, ext_reset_i, transfer_disable_select_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rdata_ch1;
   logic dtc_act_first_i, dtc_act_second_i, timer_out_o, adc_start_o;
   logic match_irq_first_o, match_irq_second_o, wrap_irq_o, irq_o;
   logic eo; // expected timer output level
   logic [1:0] mm; // output select under test
   int n_errors = 0;
   int checks_done = 0;
   tmr8s_top #(.CHANNEL(0)) i_tmr8s_top (.*);
   // second channel only answers reads; its other outputs are not watched
   tmr8s_top #(.CHANNEL(1)) i_tmr8s_top_ch1 (.*, .rdata_o(rdata_ch1), .timer_out_o(), .adc_start_o(),
      .match_irq_first_o(), .match_irq_second_o(), .wrap_irq_o(), .irq_o());
   tmr8s_dtc_model i_tmr8s_dtc_model (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .irq_first_i(match_irq_first_o),
      .irq_second_i(match_irq_second_o), .act_first_o(dtc_act_first_i), .act_second_o(dtc_act_second_i));
   // 50 MHz system clock
   initial begin
      clk_sys_i = 1'h0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one-cycle write; settles so level outputs can be checked on return
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
      @(posedge clk_sys_i);
      wr_i <= 1'h0;
      #1;
   endtask : wr
   // read both channels; channel 1 status always shows bit four set
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'h1;
      @(posedge clk_sys_i);
      rd_i <= 1'h0;
      #1;
      chk("rdata ch0", e, rdata_o);
      chk("rdata ch1", (a == A_ST) ? (e | 8'h10) : e, rdata_ch1);
   endtask : rd
   // one counter tick; returns in the cycle where its effects show
   task automatic tick;
      @(posedge clk_sys_i);
      count_tick_i <= 1'h1;
      @(posedge clk_sys_i);
      count_tick_i <= 1'h0;
      #1;
   endtask : tick
   task automatic end_sim;
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      {srst_i, ce_i, transfer_disable_select_i} = 3'h7;
      {wr_i, rd_i, count_tick_i, ext_reset_i, addr_i, wdata_i} = 16'h0000;
      eo = 1'h0;
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'h0;
      rd(A_ST, 8'h00);
      rd(A_CA, 8'hFF);
      rd(4'hF, 8'h00);
      // every select code on both fields; flags stay since nothing reads them first
      for (int f = 0; f < 2; f++) begin
         for (int m = 0; m < 4; m++) begin
            mm = ORD[2*m +: 2];
            wr(A_ST, f ? {4'h0, mm, 2'h0} : {6'h00, mm});
            wr(f ? A_CB : A_CA, 8'h05);
            wr(A_CNT, 8'h05);
            tick();
            eo = (mm == 2'h0) ? eo : (mm == 2'h1) ? 1'h0 : (mm == 2'h2) ? 1'h1 : ~eo;
            chk("timer out", {7'h00, eo}, {7'h00, timer_out_o});
            chk("adc start", 8'h00, {7'h00, adc_start_o});
            wr(f ? A_CB : A_CA, 8'hFF);
         end
      end
      rd(A_ST, 8'hCC);
      wr(A_ST, 8'hCC);
      rd(A_ST, 8'hCC);
      wr(A_ST, 8'h8C);
      rd(A_ST, 8'h8C);
      wr(A_ST, 8'h0C);
      rd(A_ST, 8'h0C);
      // converter start on first match with trigger enabled
      wr(A_ST, 8'h10);
      wr(A_CA, 8'h20);
      wr(A_CNT, 8'h20);
      tick();
      chk("adc start", 8'h01, {7'h00, adc_start_o});
      @(posedge clk_sys_i);
      #1;
      chk("adc pulse end", 8'h00, {7'h00, adc_start_o});
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk("flag first kept", 8'h01, {7'h00, match_irq_first_o});
      @(posedge clk_sys_i);
      transfer_disable_select_i <= 1'h0;
      wr(A_CB, 8'h21);
      wr(A_CNT, 8'h20);
      tick();
      tick();
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("flag first dtc", 8'h00, {7'h00, match_irq_first_o});
      chk("flag second dtc", 8'h00, {7'h00, match_irq_second_o});
      // interrupt status raised by events, masked, then unmasked and cleared
      chk("irq masked", 8'h00, {7'h00, irq_o});
      wr(`TMR8S_OFF_IRQ_MASK, 8'h02);
      chk("irq unmasked", 8'h01, {7'h00, irq_o});
      wr(`TMR8S_OFF_IRQ_STAT, 8'h02);
      chk("irq cleared", 8'h00, {7'h00, irq_o});
      rd(`TMR8S_OFF_IRQ_STAT, 8'h04);
      // wrap flag with request enabled, then the unread clear attempt
      wr(A_CTL, 8'h20);
      wr(A_CNT, 8'hFF);
      tick();
      chk("wrap irq", 8'h01, {7'h00, wrap_irq_o});
      wr(A_ST, 8'h00);
      chk("wrap unread", 8'h01, {7'h00, wrap_irq_o});
      rd(A_ST, 8'h20);
      wr(A_ST, 8'h00);
      chk("wrap cleared", 8'h00, {7'h00, wrap_irq_o});
      wr(A_CTL, 8'h00);
      wr(A_CNT, 8'hFF);
      tick();
      chk("wrap disabled", 8'h00, {7'h00, wrap_irq_o});
      // counter clear sources: none, first match, second match, external edge
      wr(A_CA, 8'h40);
      wr(A_CB, 8'h40);
      for (int c = 0; c < 4; c++) begin
         wr(A_CTL, 8'(c << 3));
         wr(A_CNT, 8'h40);
         if (c == 3) begin
            ext_reset_i <= 1'h1;
            repeat (2) @(posedge clk_sys_i);
            ext_reset_i <= 1'h0;
         end else begin
            tick();
         end
         rd(A_CNT, (c == 0) ? 8'h41 : 8'h00);
      end
      end_sim();
   end
endmodule : testbench
`default_nettype wire
